// ### hw/fbp_bridge.sv
// Steering of the modulated signal onto the four bridge outputs
`timescale 1ns/1ps
module fbp_bridge
  import fbp_pkg::*;
(
  // Steering inputs
  input wire fbp_bmode_type bmode_in,
  input wire logic dir_in,
  input wire logic blank_in,
  input wire logic pwm_in,
  // Steered outputs
  output fbp_bridge_type pins_out
);

  logic mod;

  always_comb
  begin
    pins_out = '0;
    // Modulated legs go inactive while a direction change settles
    mod = pwm_in && !blank_in;
    unique case (bmode_in)
      BR_SINGLE:
      begin
        pins_out.a = pwm_in;
      end
      BR_FULL:
      begin
        // One leg held, its diagonal modulated, no dead band inserted
        if (dir_in)
        begin
          pins_out.c = 1'b1;
          pins_out.b = mod;
        end
        else
        begin
          pins_out.a = 1'b1;
          pins_out.d = mod;
        end
      end
      default:
      begin
        pins_out = '0;
      end
    endcase
  end

endmodule : fbp_bridge

// ### hw/fbp_pkg.sv
// Shared constants and types for the full-bridge PWM steering block
package fbp_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int TMR_W = 8;
  localparam int DUTY_W = 10;
  localparam int FRAC_W = 2;
  localparam int PRE_W = 4;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_PERIOD = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_TCTRL = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_DUTY_HI = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_MCTRL = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_PIN_DIR = 8'h14;

  // Timer control fields
  localparam int TCTRL_PRE_LSB = 0;
  localparam int TCTRL_ON_BIT = 2;

  // Modulator control fields
  localparam int MCTRL_MODE_HI = 3;
  localparam int MCTRL_MODE_LO = 2;
  localparam int MCTRL_DLO_LSB = 4;
  localparam int MCTRL_FULL_BIT = 6;
  localparam int MCTRL_DIR_BIT = 7;
  localparam logic [1:0] MODE_PWM = 2'h3;

  // Status fields
  localparam int STAT_FRAC_LSB = 8;
  localparam int STAT_PWM_BIT = 10;
  localparam int STAT_BLANK_BIT = 11;
  localparam int STAT_DIR_BIT = 12;

  // Reset values
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  localparam logic [7:0] TCTRL_RST = 8'h00;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [7:0] MCTRL_RST = 8'h00;
  localparam logic [3:0] PIN_DIR_RST = 4'hF;

  // Prescaler terminal counts for divide by 1, 4 and 16
  localparam logic [PRE_W-1:0] PRE_LIM_1 = 4'h0;
  localparam logic [PRE_W-1:0] PRE_LIM_4 = 4'h3;
  localparam logic [PRE_W-1:0] PRE_LIM_16 = 4'hF;
  localparam logic [1:0] PRE_SEL_1 = 2'h0;
  localparam logic [1:0] PRE_SEL_4 = 2'h1;
  localparam logic [FRAC_W-1:0] FRAC_MAX = 2'h3;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    BR_OFF = 2'b00,
    BR_SINGLE = 2'b01,
    BR_FULL = 2'b11
  } fbp_bmode_type;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } fbp_bridge_type;

  typedef struct packed {
    logic [7:0] period;
    logic [7:0] tctrl;
    logic [7:0] duty_hi;
    logic [7:0] mctrl;
    logic [3:0] pin_dir;
    logic [DUTY_W-1:0] duty_act;
    logic dir_act;
    logic blank;
    logic pwm;
    logic wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] rdata;
    logic ready;
    logic resp;
    fbp_bridge_type pins;
    logic [3:0] oe_n;
  } fbp_top_state_type;

endpackage : fbp_pkg

// ### hw/fbp_timebase.sv
// Prescaled period timer extended by two fractional bits
`timescale 1ns/1ps
module fbp_timebase
  import fbp_pkg::*;
#(
  parameter int TW = TMR_W
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Control
  input wire logic run_in,
  input wire logic [1:0] prescale_in,
  input wire logic [TW-1:0] period_in,
  // Count
  output logic [TW-1:0] tmr_out,
  output logic [FRAC_W-1:0] frac_out,
  output logic period_end_out
);

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [TW-1:0] tmr;
    logic [FRAC_W-1:0] frac;
  } fbp_tb_state_type;

  fbp_tb_state_type st_q;
  fbp_tb_state_type st_d;
  logic [PRE_W-1:0] limit;
  logic tick;
  logic last;

  always_comb
  begin
    st_d = st_q;
    if (prescale_in == PRE_SEL_1)
    begin
      limit = PRE_LIM_1;
    end
    else if (prescale_in == PRE_SEL_4)
    begin
      limit = PRE_LIM_4;
    end
    else
    begin
      limit = PRE_LIM_16;
    end
    tick = run_in && (st_q.pre == limit);
    // Period restarts on a period-register match at the end of the fraction
    last = tick && (st_q.tmr == period_in) && (st_q.frac == FRAC_MAX);
    if (run_in)
    begin
      st_d.pre = tick ? '0 : PRE_W'(st_q.pre + 1'b1);
    end
    if (last)
    begin
      st_d.tmr = '0;
      st_d.frac = '0;
    end
    else if (tick)
    begin
      st_d.frac = FRAC_W'(st_q.frac + 1'b1);
      if (st_q.frac == FRAC_MAX)
      begin
        st_d.tmr = TW'(st_q.tmr + 1'b1);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign tmr_out = st_q.tmr;
  assign frac_out = st_q.frac;
  assign period_end_out = last;

endmodule : fbp_timebase

// ### hw/fbp_top.sv
// Full-bridge PWM generator with an AHB-Lite register slave
// How it works
// - PWM mode drives a modulated waveform with up to 10-bit duty resolution.
// - Period, duty and resolution come from period, timer, duty and control registers.
// - A new bridge direction takes effect on the held legs at once and on the modulated leg for the next modulation cycle.
// - After a direction change outputs B and D go inactive before period end.
// - On a direction change outputs A and C swap to the opposite direction.
// - Modulation restarts only at the start of the following period.
// - Forward to reverse: A and D go inactive as C goes active together.
// - No dead band in full-bridge mode; only one output is modulated.
`timescale 1ns/1ps
module fbp_top
  import fbp_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [DATA_W-1:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [DATA_W-1:0] hwdata_in,
  input wire logic hready_in,
  output logic [DATA_W-1:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Bridge pins
  output fbp_bridge_type bridge_out,
  output logic [3:0] bridge_oe_n_out
);

  logic rst_meta_q;
  logic rst_sync_q;
  fbp_top_state_type st_q;
  fbp_top_state_type st_d;
  logic [TMR_W-1:0] tmr;
  logic [FRAC_W-1:0] frac;
  logic period_end;
  logic [DUTY_W-1:0] ext_cnt;
  logic pwm_mode;
  logic full_mode;
  logic run;
  logic dir_change;
  fbp_bmode_type bmode;
  fbp_bridge_type steer;
  logic [ADDR_W-1:0] a_addr;
  logic a_take;

  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  fbp_timebase #(
    .TW(TMR_W)
  ) fbp_timebase_inst (
    .clk_in(mclk_in),
    .rstn_in(rst_sync_q),
    .run_in(run),
    .prescale_in(st_q.tctrl[TCTRL_PRE_LSB +: 2]),
    .period_in(st_q.period),
    .tmr_out(tmr),
    .frac_out(frac),
    .period_end_out(period_end)
  );

  fbp_bridge fbp_bridge_inst (
    .bmode_in(bmode),
    .dir_in(st_q.dir_act),
    .blank_in(st_q.blank),
    .pwm_in(st_q.pwm),
    .pins_out(steer)
  );

  always_comb
  begin
    pwm_mode = (st_q.mctrl[MCTRL_MODE_HI:MCTRL_MODE_LO] == MODE_PWM);
    full_mode = pwm_mode && st_q.mctrl[MCTRL_FULL_BIT];
    run = pwm_mode && st_q.tctrl[TCTRL_ON_BIT];
    ext_cnt = {tmr, frac};
    dir_change = full_mode && (st_q.mctrl[MCTRL_DIR_BIT] != st_q.dir_act);
    if (!pwm_mode)
    begin
      bmode = BR_OFF;
    end
    else if (full_mode)
    begin
      bmode = BR_FULL;
    end
    else
    begin
      bmode = BR_SINGLE;
    end
    a_addr = haddr_in[ADDR_W-1:0];
    a_take = hsel_in && hready_in && (htrans_in == HTRANS_NONSEQ);
  end

  always_comb
  begin
    st_d = st_q;
    st_d.ready = 1'b1;
    st_d.resp = 1'b0;

    // Data phase of a write
    if (st_q.wr_pend)
    begin
      unique case (st_q.wr_addr)
        ADDR_PERIOD: st_d.period = hwdata_in[7:0];
        ADDR_TCTRL: st_d.tctrl = hwdata_in[7:0];
        ADDR_DUTY_HI: st_d.duty_hi = hwdata_in[7:0];
        ADDR_MCTRL: st_d.mctrl = hwdata_in[7:0];
        ADDR_PIN_DIR: st_d.pin_dir = hwdata_in[3:0];
        default: st_d.wr_pend = 1'b0;
      endcase
    end

    // Duty is double-buffered and picked up at each period restart
    if (period_end)
    begin
      st_d.duty_act = {st_q.duty_hi, st_q.mctrl[MCTRL_DLO_LSB +: 2]};
    end

    // High from period start until the extended count meets the duty
    st_d.pwm = run && (ext_cnt < st_q.duty_act);

    // Direction switches at once; modulated legs wait for the next period
    if (dir_change)
    begin
      st_d.dir_act = st_q.mctrl[MCTRL_DIR_BIT];
      st_d.blank = 1'b1;
    end
    else if (period_end)
    begin
      st_d.blank = 1'b0;
    end
    if (!full_mode)
    begin
      st_d.dir_act = st_q.mctrl[MCTRL_DIR_BIT];
      st_d.blank = 1'b0;
    end

    st_d.pins = steer;
    // Pins drive only in PWM mode with the pin direction bit cleared
    st_d.oe_n = st_q.pin_dir | {4{!pwm_mode}};
    if (!full_mode)
    begin
      st_d.oe_n[2:0] = 3'h7;
    end

    // Address phase
    st_d.wr_pend = a_take && hwrite_in;
    st_d.wr_addr = a_addr;
    st_d.rdata = '0;
    if (a_take && !hwrite_in)
    begin
      unique case (a_addr)
        ADDR_PERIOD: st_d.rdata[7:0] = st_d.period;
        ADDR_TCTRL: st_d.rdata[7:0] = st_d.tctrl;
        ADDR_DUTY_HI: st_d.rdata[7:0] = st_d.duty_hi;
        ADDR_MCTRL: st_d.rdata[7:0] = st_d.mctrl;
        ADDR_PIN_DIR: st_d.rdata[3:0] = st_d.pin_dir;
        ADDR_STATUS:
        begin
          st_d.rdata[TMR_W-1:0] = tmr;
          st_d.rdata[STAT_FRAC_LSB +: FRAC_W] = frac;
          st_d.rdata[STAT_PWM_BIT] = st_q.pwm;
          st_d.rdata[STAT_BLANK_BIT] = st_q.blank;
          st_d.rdata[STAT_DIR_BIT] = st_q.dir_act;
        end
        default: st_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      st_q <= '0;
      st_q.period <= PERIOD_RST;
      st_q.tctrl <= TCTRL_RST;
      st_q.duty_hi <= DUTY_RST;
      st_q.mctrl <= MCTRL_RST;
      st_q.pin_dir <= PIN_DIR_RST;
      st_q.oe_n <= PIN_DIR_RST;
      st_q.ready <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign hrdata_out = st_q.rdata;
  assign hreadyout_out = st_q.ready;
  assign hresp_out = st_q.resp;
  assign bridge_out = st_q.pins;
  assign bridge_oe_n_out = st_q.oe_n;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_sync_q);

  AST_DUTY_END: assert property ((run && ext_cnt >= st_q.duty_act) |=> !st_q.pwm)
    else $error("pwm stayed high past the duty count");

  AST_PERIOD_WRAP: assert property (period_end |=> (tmr == '0 && frac == '0))
    else $error("timer did not restart after period match");

  AST_DIR_BLANK: assert property (dir_change |=> (st_q.blank && st_q.dir_act == $past(st_q.mctrl[MCTRL_DIR_BIT])))
    else $error("direction change not applied with blanking");

  AST_MOD_OFF: assert property ((full_mode && st_q.blank) |=> (!bridge_out.b && !bridge_out.d))
    else $error("modulated leg active during direction change");

  AST_SWAP: assert property ((full_mode && $changed(st_q.dir_act)) |=> (bridge_out.a != bridge_out.c))
    else $error("held legs did not swap");

  AST_RESUME: assert property ((full_mode && st_q.blank && !period_end) |=> st_q.blank)
    else $error("modulation resumed before period end");

  AST_FWD_REV: assert property ((full_mode && $rose(st_q.dir_act)) |=> (!bridge_out.a && !bridge_out.d && bridge_out.c))
    else $error("forward to reverse switch not simultaneous");

  AST_ONE_MOD: assert property ($past(full_mode) |-> !(bridge_out.b && bridge_out.d))
    else $error("both modulated legs active");

  AST_START_HIGH: assert property ((period_end && run && {st_q.duty_hi, st_q.mctrl[MCTRL_DLO_LSB +: 2]} != '0)
    ##1 run |=> st_q.pwm)
    else $error("output not high at period start");

  AST_FWD_HOLD: assert property ((full_mode && !st_q.dir_act && !st_q.blank) |=>
    (bridge_out.a && !bridge_out.b && !bridge_out.c && bridge_out.d == $past(st_q.pwm)))
    else $error("forward steering wrong");

  // Steering in each mode, one cycle behind the modulator state
  AST_SINGLE_A: assert property ((pwm_mode && !full_mode) |=>
    (bridge_out.a == $past(st_q.pwm) && !bridge_out.b && !bridge_out.c && !bridge_out.d))
    else $error("single output steering wrong");

  AST_OFF_PINS: assert property (!pwm_mode |=> (bridge_out == '0))
    else $error("outputs active with modulator off");

  AST_REV_HOLD: assert property ((full_mode && st_q.dir_act && !st_q.blank) |=>
    (bridge_out.c && !bridge_out.a && !bridge_out.d && bridge_out.b == $past(st_q.pwm)))
    else $error("reverse steering wrong");

  // Pin drivers follow the mode and the pin direction bits
  AST_OE_OFF: assert property (!pwm_mode |=> (bridge_oe_n_out == '1))
    else $error("pin driven with modulator off");

  AST_OE_SINGLE: assert property ((pwm_mode && !full_mode) |=> (bridge_oe_n_out[2:0] == '1))
    else $error("unused legs driven in single mode");

  AST_OE_FULL: assert property (full_mode |=> (bridge_oe_n_out == $past(st_q.pin_dir)))
    else $error("pin enables do not follow direction bits");

  // Timing source of the waveform
  AST_DUTY_LATCH: assert property (period_end |=>
    (st_q.duty_act == $past({st_q.duty_hi, st_q.mctrl[MCTRL_DLO_LSB +: 2]})))
    else $error("duty not picked up at period restart");

  AST_NO_RUN: assert property (!run |=> !st_q.pwm)
    else $error("modulator high while stopped");

  AST_PERIOD_WR: assert property ((a_take && hwrite_in && a_addr == ADDR_PERIOD) ##1 1'b1 |=>
    (st_q.period == $past(hwdata_in[7:0])))
    else $error("period write lost");

  // Direction handling
  AST_DIR_HOLD: assert property ((full_mode && !dir_change) |=> (st_q.dir_act == $past(st_q.dir_act)))
    else $error("applied direction moved without a request");

  AST_BLANK_END: assert property ((full_mode && st_q.blank && period_end && !dir_change) |=> !st_q.blank)
    else $error("modulation did not resume at period start");

  COV_FULL_FWD: cover property (full_mode && !st_q.dir_act && st_q.pwm);
  COV_PRESCALE: cover property (run && st_q.tctrl[TCTRL_PRE_LSB +: 2] == PRE_SEL_4 && period_end);
  COV_REVERSE: cover property (full_mode && $rose(st_q.dir_act));
  COV_RESUME: cover property (st_q.blank ##1 !st_q.blank);
  COV_READ: cover property (a_take && !hwrite_in && a_addr == ADDR_STATUS);

endmodule : fbp_top

// ### tb/fbp_switch_model.sv
// Power switch driver model at the four bridge pins
`timescale 1ns/1ps
module fbp_switch_model
  import fbp_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Bridge pins
  input wire fbp_bridge_type bridge_in,
  input wire logic [3:0] oe_n_in,
  // Switch state
  output logic [3:0] gate_out,
  output logic shoot_out
);
  // Released pins are pulled down, so a floating gate reads off
  assign gate_out = bridge_in & ~oe_n_in;
  // Sticky flag for both switches of one leg on together
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      shoot_out <= 1'b0;
    else if ((gate_out[3] & gate_out[2]) | (gate_out[1] & gate_out[0]))
      shoot_out <= 1'b1;
  end
endmodule : fbp_switch_model

// ### tb/fbp_tb_top.sv
// Self-checking bench for the full-bridge PWM steering block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module full_bridge_pwm_steering_tb_top
  import fbp_pkg::*;
();
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout;
  logic hresp;
  fbp_bridge_type bridge;
  logic [3:0] br;
  logic [3:0] oe_n;
  logic [3:0] gate;
  logic shoot;
  int failures = 0;
  int n_tests = 0;
  logic [7:0] mc [3] = '{8'h1C, 8'h0C, 8'h5C};
  int sel [3] = '{3, 3, 0};
  int hi [3] = '{9, 8, 9};
  logic [3:0] oe_exp [3] = '{4'h7, 4'h7, 4'h0};

  assign br = bridge;

  initial
  begin
    forever #2 mclk = ~mclk;
  end

  fbp_top fbp_top_inst (.mclk_in(mclk), .rstn_in(rstn), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp),
    .bridge_out(bridge), .bridge_oe_n_out(oe_n));

  fbp_switch_model fbp_switch_model_inst (.clk_in(mclk), .rstn_in(rstn), .bridge_in(bridge),
    .oe_n_in(oe_n), .gate_out(gate), .shoot_out(shoot));

  task automatic results();
    $display("counts failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    r = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    `CHK(nm, e, r)
  endtask : rdchk

  // Syncs to a rising edge, then counts high samples up to the next rise
  task automatic measure(input int s, input int per, input int h, input string nm);
    int k;
    int cnt;
    k = 0;
    cnt = 0;
    while (br[s] !== 1'b0 && k < 300)
    begin
      @(posedge mclk);
      k++;
    end
    while (br[s] !== 1'b1 && k < 300)
    begin
      @(posedge mclk);
      k++;
    end
    `CHK({nm, " sync"}, 1'b1, k < 300)
    for (int i = 0; i <= per; i++)
    begin
      cnt += int'(br[s] === 1'b1);
      @(posedge mclk);
    end
    `CHK(nm, h + 1, cnt)
  endtask : measure

  initial
  begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    `CHK("bridge rst", 4'h0, br)
    `CHK("oe rst", 4'hF, oe_n)
    rdchk(ADDR_PERIOD, 32'hFF, "period");
    rdchk(ADDR_TCTRL, 32'h0, "tctrl");
    rdchk(ADDR_DUTY_HI, 32'h0, "duty");
    rdchk(ADDR_MCTRL, 32'h0, "mctrl");
    rdchk(ADDR_PIN_DIR, 32'hF, "pin dir");
    wr(8'h18, 32'h55);
    rdchk(8'h18, 32'h0, "unmapped");
    $display("test reset done");
    wr(ADDR_PIN_DIR, 32'h0);
    wr(ADDR_PERIOD, 32'h3);
    wr(ADDR_DUTY_HI, 32'h2);
    wr(ADDR_TCTRL, 32'h4);
    for (int i = 0; i < 3; i++)
    begin
      wr(ADDR_MCTRL, {24'h0, mc[i]});
      repeat (40) @(posedge mclk);
      measure(sel[i], 16, hi[i], "duty");
      `CHK("oe", oe_exp[i], oe_n)
    end
    `CHK("fwd abc", 3'b100, br[3:1])
    $display("test duty done");
    while (br[0] !== 1'b1)
      @(posedge mclk);
    // Reverse while D is mid-pulse
    wr(ADDR_MCTRL, 32'hDC);
    repeat (3) @(posedge mclk);
    `CHK("swap", 4'b0010, br)
    repeat (4)
    begin
      @(posedge mclk);
      `CHK("blank b", 1'b0, br[2])
    end
    ahb(1'b0, ADDR_STATUS, 32'h0, rd);
    `CHK("dir applied", 1'b1, rd[STAT_DIR_BIT])
    measure(2, 16, 9, "rev b");
    `CHK("rev acd", 3'b010, {br[3], br[1], br[0]})
    $display("test reverse done");
    wr(ADDR_TCTRL, 32'h5);
    repeat (150) @(posedge mclk);
    measure(2, 64, 36, "prescale");
    wr(ADDR_MCTRL, 32'h0);
    repeat (3) @(posedge mclk);
    `CHK("off pins", 4'h0, br)
    `CHK("off oe", 4'hF, oe_n)
    `CHK("overlap", 1'b0, shoot)
    $display("test prescale and off done");
    results();
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    failures++;
    results();
  end
endmodule : full_bridge_pwm_steering_tb_top
